// [hw/hpr_decoder.sv]
// hub port request decoder with per-port feature state and an ahb-lite slave
// ----------------------------------------
// Contract
// - get port status: A3h, code 0, value 0, index port, length 4.
// - write hub descriptor (20h, code 7) always stalls.
// - hub set feature (x0100000b, code 3) always stalls.
// - port set feature: x0100011b, code 3, selector, port index, length 0.
// - selectors: enable 1, suspend 2, reset 4.
// - selectors: power 8, enable change 11h, suspend change 12h, reset change 14h.
// - set only enable/suspend/reset/power; clear only enable/suspend/over-current/power and the change selectors 10h-14h.
// - forbidden port feature requests stall and leave port state alone.
// - low speed follows the attached device, never a command.
// - hub power and over-current status stay fixed in this bus-powered hub.
// - port status request with port 0 or above 4 stalls.
// - status word: conn 0, en 1, susp 2, oc 3, reset 4, power 8, ls 9.
// - change word: conn 0, en 1, resume 2, oc 3, reset done 4.
// ----------------------------------------
module hpr_decoder
   import hpr_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic setup_valid,
   input wire logic [63:0] setup_data,
   output logic resp_ack,
   output logic resp_stall,
   output logic resp_pass,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic [3:0] port_conn_in,
   input wire logic [3:0] port_ls_in,
   input wire logic [3:0] port_oc_in,
   output logic [3:0] port_power_on,
   output logic [3:0] port_enable_on,
   output logic [3:0] port_suspend_on,
   output logic [3:0] port_reset_on,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp
);
   import hpr_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic port_valid(input logic [15:0] idx);
      return (idx >= PORT_FIRST) && (idx <= PORT_LAST);
   endfunction

   function automatic logic [15:0] status_word(input hpr_reg_t s, input logic [1:0] p);
      logic [15:0] w;
      w = '0;
      w[ST_CONN] = s.conn[p];
      w[ST_EN] = s.en[p];
      w[ST_SUSP] = s.susp[p];
      w[ST_OC] = s.oc[p];
      w[ST_RST] = s.rst[p];
      w[ST_PWR] = s.pwr[p];
      w[ST_LS] = s.ls[p];
      return w;
   endfunction

   function automatic logic [15:0] change_word(input hpr_reg_t s, input logic [1:0] p);
      logic [15:0] w;
      w = '0;
      w[CH_CONN] = s.c_conn[p];
      w[CH_EN] = s.c_en[p];
      w[CH_SUSP] = s.c_susp[p];
      w[CH_OC] = s.c_oc[p];
      w[CH_RST] = s.c_rst[p];
      return w;
   endfunction

   hpr_reg_t r;
   hpr_reg_t n;

   // ----------------------------------------
   // setup decode
   // ----------------------------------------
   logic [7:0] s_rt;
   logic [7:0] s_rq;
   logic [15:0] s_val;
   logic [15:0] s_idx;
   logic [15:0] s_len;
   logic [1:0] pidx;
   logic take;
   logic is_get;
   logic is_desc;
   logic is_hubset;
   logic is_pfeat;
   logic is_set;
   logic port_ok;
   logic set_ok;
   logic clr_ok;
   logic sel_ok;

   assign s_rt = setup_data[7:0];
   assign s_rq = setup_data[15:8];
   assign s_val = setup_data[31:16];
   assign s_idx = setup_data[47:32];
   assign s_len = setup_data[63:48];
   assign pidx = 2'(s_idx[1:0] - 2'h1);
   assign take = setup_valid && r.ctrl_en;
   assign is_get = (s_rt == RT_PORT_IN) && (s_rq == RQ_GET_STATUS)
      && (s_val == VAL_NONE) && (s_len == LEN_STATUS);
   assign is_desc = (s_rt == RT_HUB_OUT) && (s_rq == RQ_SET_DESCRIPTOR);
   assign is_hubset = ((s_rt & RT_DIR_IGNORE) == RT_HUB_OUT)
      && (s_rq == RQ_SET_FEATURE);
   assign is_pfeat = ((s_rt & RT_DIR_IGNORE) == RT_PORT_OUT)
      && ((s_rq == RQ_SET_FEATURE) || (s_rq == RQ_CLEAR_FEATURE))
      && (s_len == LEN_NONE);
   assign is_set = (s_rq == RQ_SET_FEATURE);
   assign port_ok = port_valid(s_idx);
   assign set_ok = (s_val == FS_ENABLE) || (s_val == FS_SUSPEND)
      || (s_val == FS_RESET) || (s_val == FS_POWER);
   assign clr_ok = (s_val == FS_ENABLE) || (s_val == FS_SUSPEND)
      || (s_val == FS_OVER_CURRENT) || (s_val == FS_POWER)
      || (s_val == FS_C_CONNECTION) || (s_val == FS_C_ENABLE)
      || (s_val == FS_C_SUSPEND) || (s_val == FS_C_OVER_CURRENT)
      || (s_val == FS_C_RESET);
   assign sel_ok = is_set ? set_ok : clr_ok;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      n = r;
      n.ack = 1'b0;
      n.stall = 1'b0;
      n.pass = 1'b0;
      // pin synchronisers
      n.conn_s1 = port_conn_in;
      n.conn_s2 = r.conn_s1;
      n.ls_s1 = port_ls_in;
      n.ls_s2 = r.ls_s1;
      n.oc_s1 = port_oc_in;
      n.oc_s2 = r.oc_s1;
      // data stage shifter
      if (r.state == ST_SEND && tx_ready)
      begin
         n.tx_word = {8'h00, r.tx_word[31:8]};
         n.tx_cnt = 2'(r.tx_cnt + 2'h1);
         if (r.tx_cnt == TX_LAST)
         begin
            n.state = ST_IDLE;
         end
      end
      // request handling; a new setup taken while ctrl_en is set aborts any data stage
      if (setup_valid && !r.ctrl_en)
      begin
         n.pass = 1'b1;
         n.last = LAST_PASS;
      end
      else if (take)
      begin
         n.state = ST_IDLE;
         if (is_desc || is_hubset)
         begin
            n.stall = 1'b1;
            n.last = LAST_STALL;
         end
         else if (is_get)
         begin
            if (port_ok)
            begin
               n.ack = 1'b1;
               n.tx_word = {change_word(r, pidx), status_word(r, pidx)};
               n.tx_cnt = 2'h0;
               n.state = ST_SEND;
               n.last = LAST_ACK;
            end
            else
            begin
               n.stall = 1'b1;
               n.last = LAST_STALL;
            end
         end
         else if (is_pfeat)
         begin
            if (port_ok && sel_ok)
            begin
               n.ack = 1'b1;
               n.last = LAST_ACK;
               if (is_set)
               begin
                  case (s_val)
                     FS_ENABLE: n.en[pidx] = 1'b1;
                     FS_SUSPEND: n.susp[pidx] = 1'b1;
                     FS_RESET: n.rst[pidx] = 1'b1;
                     FS_POWER: n.pwr[pidx] = 1'b1;
                     default: n.ack = 1'b1;
                  endcase
               end
               else
               begin
                  case (s_val)
                     FS_ENABLE: n.en[pidx] = 1'b0;
                     FS_SUSPEND: n.susp[pidx] = 1'b0;
                     FS_OVER_CURRENT: n.c_oc[pidx] = 1'b0;
                     FS_POWER:
                     begin
                        n.pwr[pidx] = 1'b0;
                        n.en[pidx] = 1'b0;
                     end
                     FS_C_CONNECTION: n.c_conn[pidx] = 1'b0;
                     FS_C_ENABLE: n.c_en[pidx] = 1'b0;
                     FS_C_SUSPEND: n.c_susp[pidx] = 1'b0;
                     FS_C_OVER_CURRENT: n.c_oc[pidx] = 1'b0;
                     FS_C_RESET: n.c_rst[pidx] = 1'b0;
                     default: n.ack = 1'b1;
                  endcase
               end
            end
            else
            begin
               n.stall = 1'b1;
               n.last = LAST_STALL;
            end
         end
         else
         begin
            n.pass = 1'b1;
            n.last = LAST_PASS;
         end
      end
      // firmware completion events, applied after commands so events win over same-cycle sets
      if (r.dph_wr && r.dph_addr == ADDR_EVENT)
      begin
         for (int i = 0; i < NUM_PORTS; i++)
         begin
            if (hwdata[EV_RESET_LSB + i] && r.rst[i])
            begin
               n.rst[i] = 1'b0;
               n.en[i] = r.conn[i];
               n.c_rst[i] = 1'b1;
            end
            if (hwdata[EV_RESUME_LSB + i] && r.susp[i])
            begin
               n.susp[i] = 1'b0;
               n.c_susp[i] = 1'b1;
            end
         end
      end
      // attached-device events, last so hardware sets win over clears
      n.conn = r.conn_s2;
      n.ls = r.ls_s2 & r.conn_s2;
      n.oc = r.oc_s2;
      for (int i = 0; i < NUM_PORTS; i++)
      begin
         if (r.conn_s2[i] != r.conn[i])
         begin
            n.c_conn[i] = 1'b1;
         end
         if (!r.conn_s2[i] || r.oc_s2[i])
         begin
            if (r.en[i])
            begin
               n.c_en[i] = 1'b1;
            end
            n.en[i] = 1'b0;
         end
         if (!r.conn_s2[i])
         begin
            n.susp[i] = 1'b0;
            n.rst[i] = 1'b0;
         end
         if (r.oc_s2[i] != r.oc[i])
         begin
            n.c_oc[i] = 1'b1;
         end
         if (r.oc_s2[i])
         begin
            n.pwr[i] = 1'b0;
         end
      end
      // ahb-lite slave: address phase captures, data phase writes
      n.dph_wr = 1'b0;
      if (r.dph_wr && r.dph_addr == ADDR_CTRL)
      begin
         n.ctrl_en = hwdata[CTRL_EN_BIT];
      end
      if (hsel && htrans[1] && hready)
      begin
         n.dph_wr = hwrite;
         n.dph_addr = haddr[7:0];
         n.hrdata = '0;
         if (!hwrite)
         begin
            case (haddr[7:0])
               ADDR_STATUS_LO:
                  n.hrdata = {status_word(r, 2'h1), status_word(r, 2'h0)};
               ADDR_STATUS_HI:
                  n.hrdata = {status_word(r, 2'h3), status_word(r, 2'h2)};
               ADDR_CHANGE:
                  n.hrdata = {8'(change_word(r, 2'h3)), 8'(change_word(r, 2'h2)),
                     8'(change_word(r, 2'h1)), 8'(change_word(r, 2'h0))};
               ADDR_CTRL: n.hrdata[CTRL_EN_BIT] = r.ctrl_en;
               ADDR_LAST: n.hrdata[1:0] = r.last;
               default: n.hrdata = '0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         r <= '0;
         r.ctrl_en <= CTRL_EN_RST;
      end
      else
      begin
         r <= n;
      end
   end

   assign resp_ack = r.ack;
   assign resp_stall = r.stall;
   assign resp_pass = r.pass;
   assign tx_valid = (r.state == ST_SEND);
   assign tx_data = r.tx_word[7:0];
   assign port_power_on = r.pwr;
   assign port_enable_on = r.en;
   assign port_suspend_on = r.susp;
   assign port_reset_on = r.rst;
   assign hreadyout = 1'b1;
   assign hrdata = r.hrdata;
   assign hresp = 1'b0;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   a_desc_stall: assert property (take && is_desc |=> resp_stall && !resp_ack)
      else $error("descriptor write not stalled");
   a_hub_set_stall: assert property (take && is_hubset |=> resp_stall && !tx_valid)
      else $error("hub set feature not stalled");
   a_bad_port_stall: assert property (take && is_get && !port_ok |=> resp_stall)
      else $error("bad port status request not stalled");
   a_status_first_byte: assert property (take && is_get && port_ok
      |=> resp_ack && tx_valid && tx_data == $past(8'(status_word(r, pidx))))
      else $error("status data stage wrong start");
   a_change_last_byte: assert property (take && is_get && port_ok
      ##1 (tx_ready && !setup_valid) [*3]
      |=> tx_data == $past(8'(change_word(r, pidx) >> 4'h8), 4))
      else $error("change word byte order wrong");
   a_forbidden_stall: assert property (take && is_pfeat && !sel_ok
      |=> resp_stall && $stable(port_power_on))
      else $error("forbidden feature not stalled");
   a_set_reset_port: assert property (take && is_pfeat && is_set && port_ok
      && s_val == FS_RESET && r.conn_s2[pidx]
      |=> (port_reset_on & (4'h1 << $past(pidx))) != 4'h0)
      else $error("port reset not set");
   a_clear_power_off: assert property (take && is_pfeat && !is_set && port_ok
      && s_val == FS_POWER |=> (port_power_on & (4'h1 << $past(pidx))) == 4'h0)
      else $error("port power not cleared");
   a_low_speed_pins: assert property ((r.ls & ~r.conn) == 4'h0)
      else $error("low speed without connection");
   a_set_ls_refused: assert property (take && is_pfeat && is_set
      && s_val == FS_LOW_SPEED |=> resp_stall && !resp_ack)
      else $error("low speed set accepted");

endmodule

// [include/hpr_pkg.sv]
// hub port request decoder: shared constants and types
package hpr_pkg;

   // ----------------------------------------
   // setup packet fields
   // ----------------------------------------
   localparam logic [7:0] RT_PORT_IN = 8'hA3;
   localparam logic [7:0] RT_HUB_OUT = 8'h20;
   localparam logic [7:0] RT_PORT_OUT = 8'h23;
   localparam logic [7:0] RT_DIR_IGNORE = 8'h7F;
   localparam logic [7:0] RQ_GET_STATUS = 8'h00;
   localparam logic [7:0] RQ_CLEAR_FEATURE = 8'h01;
   localparam logic [7:0] RQ_SET_FEATURE = 8'h03;
   localparam logic [7:0] RQ_SET_DESCRIPTOR = 8'h07;
   localparam logic [15:0] VAL_NONE = 16'h0000;
   localparam logic [15:0] LEN_STATUS = 16'h0004;
   localparam logic [15:0] LEN_NONE = 16'h0000;
   localparam logic [15:0] PORT_FIRST = 16'h0001;
   localparam logic [15:0] PORT_LAST = 16'h0004;
   localparam int NUM_PORTS = 4;

   // ----------------------------------------
   // feature selectors
   // ----------------------------------------
   localparam logic [15:0] FS_CONNECTION = 16'h0000;
   localparam logic [15:0] FS_ENABLE = 16'h0001;
   localparam logic [15:0] FS_SUSPEND = 16'h0002;
   localparam logic [15:0] FS_OVER_CURRENT = 16'h0003;
   localparam logic [15:0] FS_RESET = 16'h0004;
   localparam logic [15:0] FS_POWER = 16'h0008;
   localparam logic [15:0] FS_LOW_SPEED = 16'h0009;
   localparam logic [15:0] FS_C_CONNECTION = 16'h0010;
   localparam logic [15:0] FS_C_ENABLE = 16'h0011;
   localparam logic [15:0] FS_C_SUSPEND = 16'h0012;
   localparam logic [15:0] FS_C_OVER_CURRENT = 16'h0013;
   localparam logic [15:0] FS_C_RESET = 16'h0014;

   // ----------------------------------------
   // status and change word bit positions
   // ----------------------------------------
   localparam int ST_CONN = 0;
   localparam int ST_EN = 1;
   localparam int ST_SUSP = 2;
   localparam int ST_OC = 3;
   localparam int ST_RST = 4;
   localparam int ST_PWR = 8;
   localparam int ST_LS = 9;
   localparam int CH_CONN = 0;
   localparam int CH_EN = 1;
   localparam int CH_SUSP = 2;
   localparam int CH_OC = 3;
   localparam int CH_RST = 4;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_STATUS_LO = 8'h00;
   localparam logic [7:0] ADDR_STATUS_HI = 8'h04;
   localparam logic [7:0] ADDR_CHANGE = 8'h08;
   localparam logic [7:0] ADDR_EVENT = 8'h0C;
   localparam logic [7:0] ADDR_CTRL = 8'h10;
   localparam logic [7:0] ADDR_LAST = 8'h14;
   localparam int EV_RESET_LSB = 0;
   localparam int EV_RESUME_LSB = 4;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [1:0] TX_LAST = 2'h3;

   typedef enum logic [1:0] {
      LAST_NONE = 2'b00,
      LAST_ACK = 2'b01,
      LAST_STALL = 2'b10,
      LAST_PASS = 2'b11
   } hpr_last_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } hpr_state_t;

   typedef struct packed {
      logic [3:0] conn_s1;
      logic [3:0] conn_s2;
      logic [3:0] ls_s1;
      logic [3:0] ls_s2;
      logic [3:0] oc_s1;
      logic [3:0] oc_s2;
      logic [3:0] conn;
      logic [3:0] en;
      logic [3:0] susp;
      logic [3:0] oc;
      logic [3:0] rst;
      logic [3:0] pwr;
      logic [3:0] ls;
      logic [3:0] c_conn;
      logic [3:0] c_en;
      logic [3:0] c_susp;
      logic [3:0] c_oc;
      logic [3:0] c_rst;
      hpr_state_t state;
      logic [1:0] tx_cnt;
      logic [31:0] tx_word;
      logic ack;
      logic stall;
      logic pass;
      hpr_last_t last;
      logic ctrl_en;
      logic dph_wr;
      logic [7:0] dph_addr;
      logic [31:0] hrdata;
   } hpr_reg_t;

endpackage

// [sim/hpr_host_model.sv]
// host side model: sends setup packets and takes data stage bytes
module hpr_host_model
(
   input wire logic clk,
   input wire logic slow,
   input wire logic hold,
   output logic setup_valid,
   output logic [63:0] setup_data,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic [31:0] rx_word,
   output logic [2:0] rx_cnt
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      setup_valid = 1'b0;
      setup_data = 64'h0;
      tx_ready = 1'b0;
      rx_word = 32'h0;
      rx_cnt = 3'h0;
   end

   // one setup packet, byte 0 lowest; lines inverted once released
   task automatic send(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] val,
      input logic [15:0] idx, input logic [15:0] len);
      @(posedge clk);
      setup_valid <= 1'b1;
      setup_data <= {len, idx, val, rq, rt};
      @(posedge clk);
      setup_valid <= 1'b0;
      setup_data <= ~{len, idx, val, rq, rt};
   endtask

   // slow host pauses every other cycle, hold stalls fully
   always @(posedge clk)
   begin
      tx_ready <= hold ? 1'b0 : (slow ? ~tx_ready : 1'b1);
      if (setup_valid)
         rx_cnt <= 3'h0;
      else if (tx_valid && tx_ready && rx_cnt < 3'h4)
      begin
         rx_word[{rx_cnt[1:0], 3'b000} +: 8] <= tx_data;
         rx_cnt <= rx_cnt + 3'h1;
      end
   end
endmodule

// [sim/hub_port_request_decoder_tb.sv]
// self-checking testbench of the hub port request decoder
`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end

module hub_port_request_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import hpr_pkg::*;

   localparam logic [2:0] ACK = 3'h4;
   localparam logic [2:0] STL = 3'h2;
   localparam logic [2:0] PAS = 3'h1;
   typedef struct packed {
      logic [7:0] rt;
      logic [7:0] rq;
      logic [15:0] val;
      logic [15:0] idx;
      logic [15:0] len;
      logic [2:0] want;
   } hpr_row_t;

   logic clk, rstn, setup_valid, resp_ack, resp_stall, resp_pass, tx_valid, tx_ready;
   logic [63:0] setup_data;
   logic [7:0] tx_data;
   logic [3:0] port_conn_in, port_ls_in, port_oc_in;
   logic [3:0] port_power_on, port_enable_on, port_suspend_on, port_reset_on;
   logic hsel, hwrite, hreadyout, hresp, slow, hold;
   logic [31:0] haddr, hwdata, hrdata, rx_word, d;
   logic [1:0] htrans;
   logic [2:0] hsize, rx_cnt;
   wire logic hready;
   int fail_count, num_checks, cycles;
   logic [15:0] set_sel [4] = '{16'h01, 16'h02, 16'h04, 16'h08};
   logic [15:0] clr_sel [7] = '{16'h01, 16'h02, 16'h03, 16'h11, 16'h12, 16'h14, 16'h08};
   logic [15:0] chg_sel [5] = '{16'h10, 16'h11, 16'h12, 16'h13, 16'h14};
   hpr_row_t rows [18] = '{
      '{8'hA3, 8'h00, 16'h0000, 16'h0001, 16'h0004, ACK},
      '{8'hA3, 8'h00, 16'h0000, 16'h0004, 16'h0004, ACK},
      '{8'hA3, 8'h00, 16'h0000, 16'h0000, 16'h0004, STL},
      '{8'hA3, 8'h00, 16'h0000, 16'h0005, 16'h0004, STL},
      '{8'hA3, 8'h00, 16'h0000, 16'h0001, 16'h0002, PAS},
      '{8'hA3, 8'h00, 16'h0001, 16'h0001, 16'h0004, PAS},
      '{8'h20, 8'h07, 16'h1234, 16'h5678, 16'h9ABC, STL},
      '{8'h20, 8'h07, 16'h0000, 16'h0000, 16'h0000, STL},
      '{8'h20, 8'h03, 16'h0001, 16'h0000, 16'h0000, STL},
      '{8'hA0, 8'h03, 16'hFFFF, 16'hFFFF, 16'hFFFF, STL},
      '{8'h23, 8'h03, 16'h0000, 16'h0001, 16'h0000, STL},
      '{8'h23, 8'h03, 16'h0003, 16'h0002, 16'h0000, STL},
      '{8'h23, 8'h03, 16'h0009, 16'h0003, 16'h0000, STL},
      '{8'h23, 8'h03, 16'h0011, 16'h0002, 16'h0000, STL},
      '{8'h23, 8'h03, 16'h0008, 16'h0000, 16'h0000, STL},
      '{8'hA3, 8'h03, 16'h0008, 16'h0004, 16'h0000, ACK},
      '{8'h23, 8'h01, 16'h0004, 16'h0001, 16'h0000, STL},
      '{8'h23, 8'h01, 16'h0009, 16'h0001, 16'h0000, STL}
   };

   assign hready = hreadyout;

   hpr_decoder dut (.clk(clk), .rstn(rstn), .setup_valid(setup_valid),
      .setup_data(setup_data), .resp_ack(resp_ack), .resp_stall(resp_stall),
      .resp_pass(resp_pass), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .port_conn_in(port_conn_in), .port_ls_in(port_ls_in), .port_oc_in(port_oc_in),
      .port_power_on(port_power_on), .port_enable_on(port_enable_on),
      .port_suspend_on(port_suspend_on), .port_reset_on(port_reset_on), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

   hpr_host_model host (.clk(clk), .slow(slow), .hold(hold), .setup_valid(setup_valid),
      .setup_data(setup_data), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .rx_word(rx_word), .rx_cnt(rx_cnt));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // -------------------------------------
   // bus and request helpers
   // -------------------------------------
   task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      do
         @(posedge clk);
      while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do
         @(posedge clk);
      while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      ahb_xfer(1'b0, a, 32'h0, v);
      `CHK(v & m, e)
   endtask

   task automatic req(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] val,
      input logic [15:0] idx, input logic [15:0] len, input logic [2:0] want);
      host.send(rt, rq, val, idx, len);
      #1;
      `CHK({resp_ack, resp_stall, resp_pass}, want)
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         close_out();
      end
   end

   // -------------------------------------
   // main sequence
   // -------------------------------------
   initial
   begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      port_conn_in = 4'hF;
      port_ls_in = 4'h4;
      port_oc_in = 4'h0;
      slow = 1'b0;
      hold = 1'b0;
      fail_count = 0;
      num_checks = 0;
      cycles = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      #1;
      `CHK({port_power_on, port_enable_on, tx_valid, hreadyout, hresp}, 11'h2)
      rd_chk(ADDR_CTRL, 32'h1, 32'h1);
      rd_chk(8'h20, 32'hFFFF_FFFF, 32'h0);
      foreach (rows[i])
         req(rows[i].rt, rows[i].rq, rows[i].val, rows[i].idx, rows[i].len,
            rows[i].want);
      for (int p = 1; p <= NUM_PORTS; p++)
      begin
         foreach (set_sel[i])
            req(RT_PORT_OUT, RQ_SET_FEATURE, set_sel[i], 16'(p), LEN_NONE,
               ACK);
         foreach (clr_sel[i])
            req(RT_PORT_OUT, RQ_CLEAR_FEATURE, clr_sel[i], 16'(p), LEN_NONE, ACK);
      end
      // port 3 to a known state, then read it back byte by byte
      ahb_xfer(1'b1, ADDR_EVENT, 32'h44, d);
      req(RT_PORT_OUT, RQ_CLEAR_FEATURE, 16'h01, 16'h3, LEN_NONE, ACK);
      req(RT_PORT_OUT, RQ_CLEAR_FEATURE, 16'h02, 16'h3, LEN_NONE, ACK);
      foreach (chg_sel[i])
         req(RT_PORT_OUT, RQ_CLEAR_FEATURE, chg_sel[i], 16'h3, LEN_NONE, ACK);
      req(RT_PORT_OUT, RQ_SET_FEATURE, 16'h08, 16'h3, LEN_NONE, ACK);
      `CHK({port_power_on[2], port_enable_on[2], port_suspend_on[2]}, 3'h4)
      slow = 1'b1;
      req(8'hA3, RQ_GET_STATUS, VAL_NONE, 16'h3, LEN_STATUS, ACK);
      repeat (40)
         if (rx_cnt !== 3'h4)
            @(posedge clk);
      #1;
      `CHK(rx_word, 32'h0000_0301)
      `CHK(tx_valid, 1'b0)
      // full-rate host: all four bytes back to back
      slow = 1'b0;
      req(8'hA3, RQ_GET_STATUS, VAL_NONE, 16'h3, LEN_STATUS, ACK);
      repeat (6) @(posedge clk);
      #1;
      `CHK({rx_cnt, rx_word}, {3'h4, 32'h0000_0301})
      `CHK(tx_valid, 1'b0)
      req(RT_PORT_OUT, RQ_SET_FEATURE, 16'h09, 16'h3, LEN_NONE, STL);
      @(posedge clk);
      port_ls_in <= 4'h0;
      repeat (4) @(posedge clk);
      rd_chk(ADDR_STATUS_HI, 32'hFFFF, 32'h0101);
      rd_chk(ADDR_CHANGE, 32'hFFFF_FFFF, 32'h0100_0101);
      req(RT_PORT_OUT, RQ_SET_FEATURE, 16'h01, 16'h3, LEN_NONE, ACK);
      `CHK(port_enable_on[2], 1'b1)
      req(RT_PORT_OUT, RQ_SET_FEATURE, 16'h02, 16'h3, LEN_NONE, ACK);
      `CHK(port_suspend_on[2], 1'b1)
      req(RT_PORT_OUT, RQ_SET_FEATURE, 16'h04, 16'h3, LEN_NONE, ACK);
      `CHK(port_reset_on[2], 1'b1)
      // a new setup cuts a stalled data stage short
      hold = 1'b1;
      req(8'hA3, RQ_GET_STATUS, VAL_NONE, 16'h1, LEN_STATUS, ACK);
      `CHK(tx_valid, 1'b1)
      req(RT_PORT_OUT, RQ_SET_FEATURE, 16'h08, 16'h1, LEN_NONE, ACK);
      `CHK(tx_valid, 1'b0)
      hold = 1'b0;
      // decoder disabled, then read-only result register
      ahb_xfer(1'b1, ADDR_CTRL, 32'h0, d);
      req(8'hA3, RQ_GET_STATUS, VAL_NONE, 16'h1, LEN_STATUS, PAS);
      ahb_xfer(1'b1, ADDR_LAST, 32'h0, d);
      rd_chk(ADDR_LAST, 32'h3, 32'h3);
      ahb_xfer(1'b1, ADDR_CTRL, 32'h1, d);
      rd_chk(ADDR_CTRL, 32'h1, 32'h1);
      `CHK(hresp, 1'b0)
      // second reset in mid-run
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      #1;
      `CHK({port_power_on, port_enable_on, port_suspend_on, port_reset_on}, 16'h0)
      rd_chk(ADDR_LAST, 32'h3, 32'h0);
      close_out();
   end
endmodule
